// file: rtl/ocd_chan_div.sv
`timescale 1ns/1ps
module ocd_chan_div
  import ocd_pkg::*;
(
  input wire logic clk_sys_in, // System clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable.
  input wire logic load_in, // Restart with new ratio and phase.
  input wire logic run_in, // Divider may toggle.
  input wire logic tick_in, // One half period of the input clock.
  input wire logic [ocd_pkg::DIV_W-1:0] ratio_in, // Ratio minus one.
  input wire logic [ocd_pkg::PH_W-1:0] phase_in, // Phase in half periods.
  output logic clk_out // Divided clock.
);

  logic [11:0] period;
  logic [11:0] high_len;
  logic [11:0] start;
  logic [11:0] cnt_inc;
  logic [10:0] half_cnt_reg;

  // A full output period spans twice (ratio plus one) half ticks.
  assign high_len = 12'({2'h0, ratio_in} + 12'h001);
  assign period = 12'({high_len[10:0], 1'b0});
  assign start = 12'({6'h00, phase_in} % period);
  assign cnt_inc = 12'({1'b0, half_cnt_reg} + 12'h001);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      half_cnt_reg <= 11'h000;
      clk_out <= 1'b0;
    end else if (ce_in) begin
      if (load_in) begin
        half_cnt_reg <= start[10:0];
        clk_out <= start < high_len;
      end else if (!run_in) begin
        half_cnt_reg <= 11'h000;
        clk_out <= 1'b0;
      end else if (tick_in) begin
        if (cnt_inc == period) begin
          half_cnt_reg <= 11'h000;
          clk_out <= 1'b1;
        end else begin
          half_cnt_reg <= cnt_inc[10:0];
          clk_out <= cnt_inc < high_len;
        end
      end
    end
  end

endmodule

// file: rtl/ocd_out_chan.sv
`timescale 1ns/1ps
module ocd_out_chan
  import ocd_pkg::*;
(
  input wire logic clk_sys_in, // System clock, 20 MHz.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable; low freezes all state.
  input wire logic hsel_in, // AHB slave select.
  input wire logic [31:0] haddr_in, // AHB address.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hwrite_in, // AHB write.
  input wire logic [2:0] hsize_in, // AHB size.
  input wire logic [31:0] hwdata_in, // AHB write data.
  input wire logic hready_in, // AHB bus ready.
  output logic hreadyout_out, // AHB slave ready.
  output logic hresp_out, // AHB response, always OKAY.
  output logic [31:0] hrdata_out, // AHB read data.
  input wire logic prescaler_a_in, // First RF prescaler output.
  input wire logic prescaler_b_in, // Second RF prescaler output.
  input wire logic freq_lock_in, // Loop frequency lock.
  input wire logic phase_lock_in, // Loop phase lock.
  output logic out_p_out, // Positive leg level.
  output logic out_n_out, // Negative leg level.
  output logic out_p_oe_out, // Positive leg driven.
  output logic out_n_oe_out, // Negative leg driven.
  output logic hstl_mode_out, // Pair runs as HSTL.
  output logic lvds_mode_out, // Pair runs as LVDS.
  output logic cmos18_mode_out, // Pair runs on the 1.8 V CMOS driver.
  output logic cmos33_mode_out, // Pair runs on the 3.3 V CMOS driver.
  output logic drive_normal_out, // Normal CMOS drive strength.
  output logic lvds_boost_out, // LVDS 4.5 mA boost.
  output logic channel_a_powerdown_out // Channel powered down.
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic is_cmos(input logic [2:0] fmt);
    is_cmos = (fmt == FMT_CMOS_BOTH) || (fmt == FMT_CMOS_P) ||
              (fmt == FMT_CMOS_N);
  endfunction

  function automatic logic addr_hit(input logic [31:0] addr);
    addr_hit = (addr[31:14] == 18'h00000) && (addr[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus state.

  logic [7:0] sync_ctrl_reg;
  logic [7:0] drv_cfg_reg;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic [7:0] phase_reg;
  logic sync_cmd_reg;
  ocd_bus_t bus_state_reg;
  logic wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic wr_ok_reg;
  logic [IDX_W-1:0] rd_idx_reg;
  logic rd_ok_reg;
  logic [7:0] rd_byte;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // Channel state.

  logic [1:0] presc_edge;
  logic tick;
  logic freq_lock_d_reg;
  logic phase_lock_d_reg;
  logic mask_d_reg;
  logic running_reg;
  logic [DIV_W-1:0] ratio_act_reg;
  logic [PH_W-1:0] phase_act_reg;
  logic auto_evt;
  logic sync_evt;
  logic load;
  logic div_clk;
  logic mask;
  logic pd;
  logic cmos33;
  logic [2:0] fmt;
  logic [1:0] pol;
  logic drv_en;
  logic p_on;
  logic n_on;
  logic ck;

  assign mask = sync_ctrl_reg[SYNC_MASK_BIT];
  assign pd = div_hi_reg[HI_PD_BIT];
  assign cmos33 = drv_cfg_reg[DRV_CMOS33_BIT];
  assign fmt = drv_cfg_reg[DRV_FMT_LSB +: 3];
  assign pol = drv_cfg_reg[DRV_POL_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes complete with no wait, reads take one wait.

  assign access = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_ok_reg <= 1'b0;
    end else if (ce_in) begin
      wr_pend_reg <= access && hwrite_in;
      wr_idx_reg <= haddr_in[IDX_W+1:2];
      wr_ok_reg <= addr_hit(haddr_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      bus_state_reg <= ST_IDLE;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h00000000;
      rd_idx_reg <= '0;
      rd_ok_reg <= 1'b0;
    end else if (ce_in) begin
      case (bus_state_reg)
        ST_IDLE: begin
          if (access && !hwrite_in) begin
            bus_state_reg <= ST_RD_FETCH;
            hreadyout_out <= 1'b0;
            rd_idx_reg <= haddr_in[IDX_W+1:2];
            rd_ok_reg <= addr_hit(haddr_in);
          end
        end
        ST_RD_FETCH: begin
          bus_state_reg <= ST_IDLE;
          hreadyout_out <= 1'b1;
          hrdata_out <= rd_ok_reg ? {24'h000000, rd_byte} : 32'h00000000;
        end
        default: begin
          bus_state_reg <= ST_IDLE;
          hreadyout_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      hresp_out <= 1'b0;
    end
  end

  // Read mux; reserved bits and unmapped words read as zero.
  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx_reg)
      IDX_SYNC_CTRL: rd_byte = sync_ctrl_reg & 8'h37;
      IDX_DRV_CFG: rd_byte = drv_cfg_reg;
      IDX_DIV_LO: rd_byte = div_lo_reg;
      IDX_DIV_HI: rd_byte = div_hi_reg & 8'h0f;
      IDX_PHASE: rd_byte = phase_reg & 8'h3f;
      IDX_STATUS: rd_byte = {4'h0, drv_en, cmos33, div_clk, running_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync_ctrl_reg <= RST_SYNC_CTRL;
      drv_cfg_reg <= RST_DRV_CFG;
      div_lo_reg <= RST_DIV_LO;
      div_hi_reg <= RST_DIV_HI;
      phase_reg <= RST_PHASE;
    end else if (ce_in && wr_pend_reg && wr_ok_reg) begin
      case (wr_idx_reg)
        IDX_SYNC_CTRL: sync_ctrl_reg <= hwdata_in[7:0] & 8'h37;
        IDX_DRV_CFG: drv_cfg_reg <= hwdata_in[7:0];
        IDX_DIV_LO: div_lo_reg <= hwdata_in[7:0];
        IDX_DIV_HI: div_hi_reg <= hwdata_in[7:0] & 8'h0f;
        IDX_PHASE: phase_reg <= hwdata_in[7:0] & 8'h3f;
        default: begin
        end
      endcase
    end
  end

  // Writing a one to the command bit raises a single sync pulse.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync_cmd_reg <= 1'b0;
    end else if (ce_in) begin
      sync_cmd_reg <= wr_pend_reg && wr_ok_reg &&
                      (wr_idx_reg == IDX_SYNC_CMD) &&
                      hwdata_in[CMD_SYNC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler inputs come from another clock; each edge is half a period.

  for (genvar i = 0; i < 2; i++) begin : g_presc_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
      end else if (ce_in) begin
        s1_reg <= (i == 0) ? prescaler_a_in : prescaler_b_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    assign presc_edge[i] = s2_reg ^ s3_reg;
  end

  assign tick = div_hi_reg[HI_PSEL_BIT] ? presc_edge[1] : presc_edge[0];

  ////////////////////////////////////////////////////////////////////////////
  // Sync sourcing and divider release.

  always_comb begin
    case (ocd_auto_t'(sync_ctrl_reg[SYNC_AUTO_LSB +: 2]))
      AUTO_FREQ: auto_evt = freq_lock_in && !freq_lock_d_reg;
      AUTO_PHASE: auto_evt = phase_lock_in && !phase_lock_d_reg;
      default: auto_evt = 1'b0;
    endcase
  end

  assign sync_evt = sync_cmd_reg || auto_evt;
  // A set mask ignores sync; raising the mask releases the divider.
  assign load = (sync_evt && !mask) || (mask && !mask_d_reg);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      freq_lock_d_reg <= 1'b0;
      phase_lock_d_reg <= 1'b0;
      mask_d_reg <= 1'b0;
    end else if (ce_in) begin
      freq_lock_d_reg <= freq_lock_in;
      phase_lock_d_reg <= phase_lock_in;
      mask_d_reg <= mask;
    end
  end

  // Ratio and phase are shadowed and latched on a load, which restarts the divider at the phase latched by the previous load.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      running_reg <= 1'b0;
      ratio_act_reg <= '0;
      phase_act_reg <= '0;
    end else if (ce_in && load) begin
      running_reg <= 1'b1;
      ratio_act_reg <= {div_hi_reg[1:0], div_lo_reg};
      phase_act_reg <= phase_reg[PH_W-1:0];
    end
  end

  ocd_chan_div u_div (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .load_in(load),
    .run_in(running_reg && !pd),
    .tick_in(tick),
    .ratio_in(ratio_act_reg),
    .phase_in(phase_act_reg),
    .clk_out(div_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output driver pair.

  assign drv_en = cmos33 || drv_cfg_reg[DRV_EN_BIT];
  assign ck = div_clk && running_reg && !pd;

  always_comb begin
    if (cmos33) begin
      // A non-CMOS format under the 3.3 V driver runs both legs.
      p_on = drv_en && (fmt != FMT_CMOS_N);
      n_on = drv_en && (fmt != FMT_CMOS_P);
    end else begin
      p_on = drv_en && ((fmt == FMT_HSTL) || (fmt == FMT_LVDS) ||
                        (fmt == FMT_CMOS_BOTH) || (fmt == FMT_CMOS_P));
      n_on = drv_en && ((fmt == FMT_HSTL) || (fmt == FMT_LVDS) ||
                        (fmt == FMT_CMOS_BOTH) || (fmt == FMT_CMOS_N));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      out_p_out <= 1'b0;
      out_n_out <= 1'b0;
      out_p_oe_out <= 1'b0;
      out_n_oe_out <= 1'b0;
    end else if (ce_in) begin
      out_p_out <= p_on && (ck ^ pol[1]);
      out_n_out <= n_on && (!ck ^ pol[1] ^ pol[0]);
      out_p_oe_out <= p_on;
      out_n_oe_out <= n_on;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hstl_mode_out <= 1'b0;
      lvds_mode_out <= 1'b0;
      cmos18_mode_out <= 1'b0;
      cmos33_mode_out <= 1'b0;
      drive_normal_out <= 1'b0;
      lvds_boost_out <= 1'b0;
      channel_a_powerdown_out <= 1'b0;
    end else if (ce_in) begin
      hstl_mode_out <= drv_en && !cmos33 && (fmt == FMT_HSTL);
      lvds_mode_out <= drv_en && !cmos33 && (fmt == FMT_LVDS);
      cmos18_mode_out <= drv_en && !cmos33 && is_cmos(fmt);
      cmos33_mode_out <= cmos33;
      // The 1.8 V driver always runs at low strength.
      drive_normal_out <= cmos33 && drv_cfg_reg[DRV_STR_BIT];
      lvds_boost_out <= drv_en && !cmos33 && (fmt == FMT_LVDS) &&
                        drv_cfg_reg[DRV_STR_BIT];
      channel_a_powerdown_out <= pd;
    end
  end

endmodule

// file: rtl/ocd_pkg.sv
package ocd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int unsigned DIV_W = 10;
  localparam int unsigned PH_W = 6;
  localparam int unsigned IDX_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h500;
  localparam logic [11:0] IDX_DRV_CFG = 12'h501;
  localparam logic [11:0] IDX_DIV_LO = 12'h502;
  localparam logic [11:0] IDX_DIV_HI = 12'h503;
  localparam logic [11:0] IDX_PHASE = 12'h504;
  localparam logic [11:0] IDX_SYNC_CMD = 12'h50e;
  localparam logic [11:0] IDX_STATUS = 12'h50f;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned DRV_CMOS33_BIT = 7;
  localparam int unsigned DRV_FMT_LSB = 4;
  localparam int unsigned DRV_POL_LSB = 2;
  localparam int unsigned DRV_STR_BIT = 1;
  localparam int unsigned DRV_EN_BIT = 0;
  localparam int unsigned HI_PD_BIT = 3;
  localparam int unsigned HI_PSEL_BIT = 2;
  localparam int unsigned SYNC_MASK_BIT = 4;
  localparam int unsigned SYNC_AUTO_LSB = 0;
  localparam int unsigned CMD_SYNC_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_SYNC_CTRL = 8'h02;
  localparam logic [7:0] RST_DRV_CFG = 8'h10;
  localparam logic [7:0] RST_DIV_LO = 8'h00;
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings.
  typedef enum logic [2:0] {
    FMT_PD = 3'h0,
    FMT_HSTL = 3'h1,
    FMT_LVDS = 3'h2,
    FMT_RSV3 = 3'h3,
    FMT_CMOS_BOTH = 3'h4,
    FMT_CMOS_P = 3'h5,
    FMT_CMOS_N = 3'h6,
    FMT_RSV7 = 3'h7
  } ocd_fmt_t;

  typedef enum logic [1:0] {
    AUTO_OFF = 2'h0,
    AUTO_FREQ = 2'h1,
    AUTO_PHASE = 2'h2,
    AUTO_RSV = 2'h3
  } ocd_auto_t;

  typedef enum {
    ST_IDLE,
    ST_RD_FETCH
  } ocd_bus_t;

endpackage

// file: tb/ocd_load.sv
`timescale 1ns/1ps
module ocd_load (
  input wire logic clk_sys_in, // Clock.
  input wire logic srst_in, // Reset.
  input wire logic leg_in, // Leg level.
  input wire logic oe_in, // Leg driven.
  output logic [15:0] hi_len_out, // Last complete high run in cycles.
  output logic [15:0] rises_out // Rising edges seen.
);
  logic [15:0] run_reg;
  logic prev_reg;
  logic hi;
  // A leg that is not driven counts as low.
  assign hi = leg_in && oe_in;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      run_reg <= 16'h0;
      prev_reg <= 1'b0;
      hi_len_out <= 16'h0;
      rises_out <= 16'h0;
    end else begin
      prev_reg <= hi;
      run_reg <= hi ? run_reg + 16'h1 : 16'h0;
      if (prev_reg && !hi) begin
        hi_len_out <= run_reg;
      end
      if (!prev_reg && hi) begin
        rises_out <= rises_out + 16'h1;
      end
    end
  end
endmodule

// file: tb/ocd_out_chan_chk.sv
`timescale 1ns/1ps
module ocd_out_chan_chk (
  input wire logic clk_sys_in, // Clock.
  input wire logic srst_in, // Reset.
  input wire logic ce_in, // Enable.
  input wire logic hsel_in, // Select.
  input wire logic [1:0] htrans_in, // Transfer type.
  input wire logic hwrite_in, // Write.
  input wire logic hready_in, // Bus ready.
  input wire logic hreadyout_out, // Slave ready.
  input wire logic hresp_out, // Response.
  input wire logic [31:0] hrdata_out, // Read data.
  input wire logic out_p_out, // P level.
  input wire logic out_n_out, // N level.
  input wire logic out_p_oe_out, // P driven.
  input wire logic out_n_oe_out, // N driven.
  input wire logic hstl_mode_out, // HSTL.
  input wire logic lvds_mode_out, // LVDS.
  input wire logic cmos18_mode_out, // CMOS 1.8 V.
  input wire logic cmos33_mode_out, // CMOS 3.3 V.
  input wire logic drive_normal_out, // Normal strength.
  input wire logic lvds_boost_out, // LVDS boost.
  input wire logic channel_a_powerdown_out // Powered down.
);
  logic acc;
  logic wacc;
  logic [3:0] modes;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  assign acc = hsel_in && hready_in && htrans_in[1] && ce_in;
  assign wacc = acc && hwrite_in;
  assign modes = {hstl_mode_out, lvds_mode_out, cmos18_mode_out,
                  cmos33_mode_out};

  ////////////////////////////////////////////////////////////////////////////
  AST_RD_WAIT: assert property (
    acc && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  AST_WR_ZERO: assert property (acc && hwrite_in |=> hreadyout_out)
    else $error("write not zero wait");
  AST_OKAY: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  AST_RD_HOLD: assert property ($past(hreadyout_out) |-> $stable(hrdata_out))
    else $error("read data changed outside a read");
  AST_P_OFF: assert property (
    !out_p_oe_out |-> !out_p_out) else $error("undriven p leg not low");
  AST_N_OFF: assert property (
    !out_n_oe_out |-> !out_n_out) else $error("undriven n leg not low");
  AST_ONE_MODE: assert property (
    $onehot0(modes)) else $error("several driver modes at once");
  AST_DRIVEN_MODE: assert property (
    out_p_oe_out || out_n_oe_out |-> $onehot(modes))
    else $error("leg driven without one mode");
  AST_DIFF_LEGS: assert property (
    hstl_mode_out || lvds_mode_out |-> out_p_oe_out && out_n_oe_out)
    else $error("differential mode without both legs");
  AST_NORMAL33: assert property (
    drive_normal_out |-> cmos33_mode_out)
    else $error("normal strength off the 3.3 V driver");
  AST_BOOST: assert property (
    lvds_boost_out |-> lvds_mode_out) else $error("boost outside LVDS");
  AST_PD_STILL: assert property (
    channel_a_powerdown_out && $past(channel_a_powerdown_out, 2) &&
    !$past(wacc, 3) |-> $stable(out_p_out))
    else $error("output moves while powered down");

  C_READ: cover property (acc && !hwrite_in);
  C_WRITE: cover property (acc && hwrite_in);
  C_CMOS33: cover property (cmos33_mode_out && drive_normal_out);
  C_BOOST: cover property (lvds_boost_out);
endmodule

bind ocd_out_chan ocd_out_chan_chk u_chk (.clk_sys_in, .srst_in, .ce_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hresp_out,
  .hrdata_out, .out_p_out, .out_n_out, .out_p_oe_out, .out_n_oe_out,
  .hstl_mode_out, .lvds_mode_out, .cmos18_mode_out, .cmos33_mode_out,
  .drive_normal_out, .lvds_boost_out, .channel_a_powerdown_out);

// file: tb/tb_output_channel_divider_config.sv
`timescale 1ns/1ps
module tb_output_channel_divider_config;
  import ocd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic prescaler_a_in = 1'b0, prescaler_b_in = 1'b0;
  logic freq_lock_in = 1'b0, phase_lock_in = 1'b0;
  logic hready_in, hreadyout_out, hresp_out, out_p_out, out_n_out;
  logic out_p_oe_out, out_n_oe_out, hstl_mode_out, lvds_mode_out;
  logic cmos18_mode_out, cmos33_mode_out, drive_normal_out, lvds_boost_out;
  logic channel_a_powerdown_out;
  logic [31:0] hrdata_out, v;
  logic [31:0] seed = 32'h9c9a;
  logic [15:0] hi_len, rises;
  logic [7:0] seen_mode;
  int miscompares = 0, n_compared = 0, pcnt = 0, k, n0, n1;
  logic [11:0] idx_tab [6] = '{IDX_SYNC_CTRL, IDX_DRV_CFG, IDX_DIV_LO,
                               IDX_DIV_HI, IDX_PHASE, 12'h505};
  logic [7:0] rst_tab [6] = '{8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk_tab [6] = '{8'h37, 8'hff, 8'hff, 8'h0f, 8'h3f, 8'h00};

  assign hready_in = hreadyout_out;
  assign seen_mode = {out_p_oe_out, out_n_oe_out, hstl_mode_out,
    lvds_mode_out, cmos18_mode_out, cmos33_mode_out, drive_normal_out,
    lvds_boost_out};

  ocd_out_chan u_dut (.clk_sys_in, .srst_in, .ce_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
    .hreadyout_out, .hresp_out, .hrdata_out, .prescaler_a_in,
    .prescaler_b_in, .freq_lock_in, .phase_lock_in, .out_p_out, .out_n_out,
    .out_p_oe_out, .out_n_oe_out, .hstl_mode_out, .lvds_mode_out,
    .cmos18_mode_out, .cmos33_mode_out, .drive_normal_out, .lvds_boost_out,
    .channel_a_powerdown_out);
  ocd_load u_load (.clk_sys_in, .srst_in, .leg_in(out_p_out),
    .oe_in(out_p_oe_out), .hi_len_out(hi_len), .rises_out(rises));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_sys_in = !clk_sys_in;
  end
  // Prescaler a has a half period of 4 cycles, prescaler b of 6.
  always @(posedge clk_sys_in) begin
    pcnt <= pcnt + 1;
    if (pcnt % 4 == 3) prescaler_a_in <= !prescaler_a_in;
    if (pcnt % 6 == 5) prescaler_b_in <= !prescaler_b_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_mode(input logic [7:0] c);
    logic [2:0] f;
    logic on, c33, p, n, c18;
    f = c[6:4];
    c33 = c[7];
    on = c33 || c[0];
    p = on && (f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h5);
    n = on && (f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h6);
    c18 = on && !c33 && f[2] && (p || n);
    return {p, n, on && !c33 && f == 3'h1, on && !c33 && f == 3'h2, c18,
            c33, c33 && c[1], on && !c33 && f == 3'h2 && c[1]};
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic bus(input logic w, input logic [11:0] idx,
      input logic [7:0] wd, output logic [31:0] r);
    int t;
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {18'h0, idx, 2'h0};
    for (int p = 0; p < 2; p++) begin
      t = 0;
      do begin
        @(posedge clk_sys_in);
        t++;
      end while (hreadyout_out !== 1'b1 && t < 50);
      if (t >= 50) begin
        miscompares++;
        give_verdict();
      end
      htrans_in <= 2'h0;
      hwdata_in <= {24'h0, wd};
    end
    r = hrdata_out;
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  task automatic rdchk(input logic [11:0] i, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, i, 8'h0, r);
    chk($sformatf("reg %h", i), r, {24'h0, e});
  endtask
  // Waits for three rising edges, so the last high run is a whole one.
  task automatic meas(input int len);
    logic [15:0] r0;
    int t;
    r0 = rises;
    t = 0;
    while (rises < r0 + 16'h3 && t < 12000) begin
      @(posedge clk_sys_in);
      t++;
    end
    if (t >= 12000) begin
      miscompares++;
      give_verdict();
    end
    chk("high run", 32'(hi_len), len);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    srst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rdchk(idx_tab[i], rst_tab[i]);
    for (int i = 0; i < 24; i++) begin
      k = i % 6;
      v = rnd();
      v[4] = (k == 0) ? 1'b0 : v[4];
      if (k == 1 && (!v[6] || v[5:4] == 2'h3)) v[7] = 1'b0;
      wr(idx_tab[k], v[7:0]);
      rdchk(idx_tab[k], v[7:0] & msk_tab[k]);
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      v[6:4] = i[2:0];
      v[7] = i[3] && v[6] && i[2:0] != 3'h7;
      wr(IDX_DRV_CFG, v[7:0]);
      cyc(3);
      chk("mode", 32'(seen_mode), 32'(exp_mode(v[7:0])));
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_DRV_CFG, {4'h4, i[1:0], 2'h1});
      cyc(3);
      chk("pol", 32'({out_p_out, out_n_out}), {i[1], !i[1] ^ i[0]});
    end
    n0 = rises;
    cyc(40);
    chk("static", 32'(rises), n0);
    n0 = rnd() % 8;
    n1 = (n0 + 3) % 8;
    wr(IDX_DRV_CFG, 8'h41);
    wr(IDX_DIV_HI, 8'h00);
    wr(IDX_DIV_LO, 8'(n0));
    wr(IDX_SYNC_CTRL, 8'h01);
    freq_lock_in <= 1'b1;
    meas((n0 + 1) * 4);
    wr(IDX_DIV_LO, 8'(n1));
    meas((n0 + 1) * 4);
    wr(IDX_SYNC_CTRL, 8'h02);
    phase_lock_in <= 1'b1;
    meas((n1 + 1) * 4);
    wr(IDX_DIV_LO, 8'h00);
    wr(IDX_SYNC_CTRL, 8'h10);
    meas(4);
    wr(IDX_DIV_LO, 8'h05);
    wr(IDX_SYNC_CMD, 8'h01);
    meas(4);
    wr(IDX_DIV_HI, 8'h08);
    cyc(3);
    chk("pd", 32'(channel_a_powerdown_out), 32'h1);
    n0 = rises;
    cyc(60);
    chk("pd edges", 32'(rises), n0);
    wr(IDX_DIV_HI, 8'h00);
    meas(4);
    ce_in <= 1'b0;
    cyc(2);
    n0 = rises;
    cyc(40);
    chk("ce freeze", 32'(rises), n0);
    ce_in <= 1'b1;
    wr(IDX_SYNC_CTRL, 8'h00);
    wr(IDX_DIV_LO, 8'h02);
    wr(IDX_DIV_HI, 8'h05);
    wr(IDX_SYNC_CMD, 8'h01);
    meas(259 * 6);
    give_verdict();
  end
endmodule
